//--- rtl/offset_prog_defines.vh
// Constants for the flag offset programming block
`ifndef OFFSET_PROG_DEFINES_VH
`define OFFSET_PROG_DEFINES_VH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define OFS_W            17
`define BUS_W            18
`define PTR_W            3
`define SCNT_W           6
`define NBITS_W          5

// ----------------------------------------------------------------
// Significant bits and depth codes
// ----------------------------------------------------------------
`define BITS_X9_BASE     5'h0E
`define BITS_OTHER_BASE  5'h0D
`define DEPTH_DEEPEST    2'h3
`define DEPTH_DEFAULT    2'h3

// ----------------------------------------------------------------
// Reset values of the offset registers
// ----------------------------------------------------------------
`define EMPTY_OFS_RST    17'h0007F
`define FULL_OFS_RST     17'h0007F

// ----------------------------------------------------------------
// Synchroniser
// ----------------------------------------------------------------
`define SYNC_STAGES      2

`endif

//--- rtl/pin_sync.v
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps

module pin_sync #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input  wire             sys_clk,
    input  wire             sys_rst,
    // Asynchronous pins in, synchronised levels out
    input  wire [WIDTH-1:0] pin_in,
    output wire [WIDTH-1:0] pin_out
);

    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    // First stage is read only by the second stage
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_out = sync_q;

endmodule

//--- rtl/fifo_flag_offset_programmer.v
// Almost-empty / almost-full offset register bank with parallel, serial load
`timescale 1ns/10ps
`include "offset_prog_defines.vh"

// Function
// RULE1 - Parallel write stores words: empty low, empty high, full low, full high
// RULE2 - Parallel read presents next offset word per read-clock edge, same order
// RULE3 - Serial mode shifts one bit per write-clock edge, empty LSB first
// RULE4 - Significant bits depend on depth and mode; unused bits ignored on write
// RULE5 - Nine-bit port carries bits 1-8 then 9-16 on lines 0-7
// RULE6 - Deepest x9-to-x9 adds third word carrying bit 17 on line 0
// RULE7 - Deepest x9 in, x18 out programs in four write cycles
// RULE8 - Deepest x9 out, x18 in reads back in four cycles
// RULE9 - Deepest x9-to-x9 program or readback takes six cycles
// RULE10 - Serial or parallel load choice latched only during master reset
// RULE11 - Same sequence in fall-through and standard timing modes
// RULE12 - Eighteen-bit port moves a register per cycle, parity layout optional
// RULE13 - Independent write and read pointers; master reset clears them
// RULE14 - Load select high routes enables to memory; resume at next word
// RULE15 - Controller must not read and write offsets at once
module fifo_flag_offset_programmer #(
    parameter [1:0] DEPTH_SEL = `DEPTH_DEFAULT
) (
    // Clock and reset
    input  wire              sys_clk,
    input  wire              sys_rst,
    // Controller pins, asynchronous to sys_clk
    input  wire              master_reset_n,
    input  wire              offset_load_select_n,
    input  wire              wr_en_n,
    input  wire              rd_en_n,
    input  wire              serial_shift_en_n,
    input  wire              serial_in,
    input  wire              write_clk_pin,
    input  wire              read_clk_pin,
    input  wire [`BUS_W-1:0] in_data_bus,
    // Configuration pins, taken during master reset
    input  wire              in_width_sel,
    input  wire              out_width_sel,
    input  wire              parity_sel,
    input  wire              fall_through_mode,
    // Readback port
    output reg  [`BUS_W-1:0] out_data_bus,
    output reg               out_data_valid,
    // Memory access strobes
    output reg               mem_write_pulse,
    output reg               mem_read_pulse,
    // Offset and mode state
    output reg  [`OFS_W-1:0] empty_offset,
    output reg  [`OFS_W-1:0] full_offset,
    output reg               serial_mode,
    output reg               fall_through_latched
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function [`NBITS_W-1:0] sig_bits;
        input       x9x9;
        input [1:0] dsel;
        begin
            sig_bits = (x9x9 ? `BITS_X9_BASE : `BITS_OTHER_BASE) + {3'h0, dsel};
        end
    endfunction

    function [`PTR_W-1:0] words_per_reg;
        input is18;
        input deep9;
        begin
            if (is18)
                words_per_reg = 3'h1;
            else if (deep9)
                words_per_reg = 3'h3;
            else
                words_per_reg = 3'h2;
        end
    endfunction

    // Place one bus word into an offset register
    function [`OFS_W-1:0] put_word;
        input [`OFS_W-1:0] old;
        input [1:0]        idx;
        input [`BUS_W-1:0] d;
        input              is18;
        input              par;
        reg   [`OFS_W-1:0] r;
        begin
            r = old;
            if (is18) begin
                if (par)
                    r[15:0] = {d[16:9], d[7:0]}; // RULE12
                else
                    r[15:0] = d[15:0]; // RULE12
            end else begin
                case (idx)
                    2'h0: r[7:0] = d[7:0]; // RULE5
                    2'h1: r[15:8] = d[7:0]; // RULE5
                    default: r[16] = d[0]; // RULE6
                endcase
            end
            put_word = r;
        end
    endfunction

    // Pick one bus word out of an offset register; unused lines read zero
    function [`BUS_W-1:0] get_word;
        input [`OFS_W-1:0] v;
        input [1:0]        idx;
        input              is18;
        input              par;
        begin
            if (is18)
                get_word = par ? {1'b0, v[15:8], 1'b0, v[7:0]} : {2'h0, v[15:0]};
            else begin
                case (idx)
                    2'h0: get_word = {10'h000, v[7:0]};
                    2'h1: get_word = {10'h000, v[15:8]};
                    default: get_word = {17'h00000, v[16]};
                endcase
            end
        end
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisation and edge detection
    // ------------------------------------------------------------
    wire [29:0] pins_s;
    wire        mrs_n_s;
    wire        ld_n_s;
    wire        wen_n_s;
    wire        ren_n_s;
    wire        sen_n_s;
    wire        si_s;
    wire        wclk_s;
    wire        rclk_s;
    wire        iw_s;
    wire        ow_s;
    wire        par_s;
    wire        ffm_s;
    wire [`BUS_W-1:0] din_s;

    pin_sync #(
        .WIDTH (30)
    ) u_pin_sync (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .pin_in  ({master_reset_n, offset_load_select_n, wr_en_n, rd_en_n,
                   serial_shift_en_n, serial_in, write_clk_pin, read_clk_pin,
                   in_width_sel, out_width_sel, parity_sel, fall_through_mode,
                   in_data_bus}),
        .pin_out (pins_s)
    );

    assign {mrs_n_s, ld_n_s, wen_n_s, ren_n_s, sen_n_s, si_s, wclk_s, rclk_s,
            iw_s, ow_s, par_s, ffm_s, din_s} = pins_s;

    reg wclk_prev_q;
    reg rclk_prev_q;

    // Data and controls share the same delay as the clocks, so they line up
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wclk_prev_q <= 1'b0;
            rclk_prev_q <= 1'b0;
        end else begin
            wclk_prev_q <= wclk_s;
            rclk_prev_q <= rclk_s;
        end
    end

    wire wclk_rise = wclk_s & ~wclk_prev_q;
    wire rclk_rise = rclk_s & ~rclk_prev_q;

    // ------------------------------------------------------------
    // Configuration and decode
    // ------------------------------------------------------------
    reg iw18_q;
    reg ow18_q;
    reg par_q;

    wire               x9x9      = ~iw18_q & ~ow18_q;
    wire               deep9     = x9x9 & (DEPTH_SEL == `DEPTH_DEEPEST);
    wire [`NBITS_W-1:0] nbits    = sig_bits(x9x9, DEPTH_SEL); // RULE4
    wire [`OFS_W-1:0]  ofs_mask  = {`OFS_W{1'b1}} >> (5'h11 - nbits); // RULE4
    wire [`PTR_W-1:0]  wr_wpr    = words_per_reg(iw18_q, deep9); // RULE7 RULE9
    wire [`PTR_W-1:0]  rd_wpr    = words_per_reg(ow18_q, deep9); // RULE8 RULE9

    // Offset operations; fall-through mode is not consulted here
    wire par_wr  = wclk_rise & ~ld_n_s & ~wen_n_s & ren_n_s & sen_n_s
                   & ~serial_mode; // RULE1 RULE11
    wire ser_wr  = wclk_rise & ~ld_n_s & wen_n_s & ren_n_s & ~sen_n_s
                   & serial_mode; // RULE3 RULE11
    wire par_rd  = rclk_rise & ~ld_n_s & wen_n_s & ~ren_n_s & sen_n_s; // RULE2
    wire mem_wr  = wclk_rise & ld_n_s & ~wen_n_s; // RULE14
    wire mem_rd  = rclk_rise & ld_n_s & ~ren_n_s; // RULE14

    // ------------------------------------------------------------
    // Pointers and offset registers
    // ------------------------------------------------------------
    reg [`PTR_W-1:0]  wr_ptr_q;
    reg [`PTR_W-1:0]  wr_ptr_d;
    reg [`PTR_W-1:0]  rd_ptr_q;
    reg [`PTR_W-1:0]  rd_ptr_d;
    reg [`SCNT_W-1:0] sbit_q;
    reg [`SCNT_W-1:0] sbit_d;
    reg [`OFS_W-1:0]  empty_d;
    reg [`OFS_W-1:0]  full_d;
    reg [`BUS_W-1:0]  rd_word;
    reg [`PTR_W-1:0]  wi;
    reg [`PTR_W-1:0]  ri;
    reg [`NBITS_W-1:0] fpos;

    wire wr_full_sel = (wr_ptr_q >= wr_wpr);
    wire rd_full_sel = (rd_ptr_q >= rd_wpr);

    // Next-state of the bank; pointers wrap after the full-offset last word
    always @* begin
        wr_ptr_d = wr_ptr_q;
        rd_ptr_d = rd_ptr_q;
        sbit_d   = sbit_q;
        empty_d  = empty_offset;
        full_d   = full_offset;
        wi       = wr_full_sel ? wr_ptr_q - wr_wpr : wr_ptr_q;
        ri       = rd_full_sel ? rd_ptr_q - rd_wpr : rd_ptr_q;
        fpos     = sbit_q[`NBITS_W-1:0] - nbits;
        rd_word  = get_word(rd_full_sel ? full_offset : empty_offset, ri[1:0],
                            ow18_q, par_q); // RULE2 RULE12
        if (par_wr) begin
            if (wr_full_sel)
                full_d = put_word(full_offset, wi[1:0], din_s, iw18_q, par_q)
                         & ofs_mask; // RULE1 RULE4
            else
                empty_d = put_word(empty_offset, wi[1:0], din_s, iw18_q, par_q)
                          & ofs_mask; // RULE1 RULE4
            wr_ptr_d = (wr_ptr_q + 3'h1 == {wr_wpr[1:0], 1'b0}) ? 3'h0
                       : wr_ptr_q + 3'h1; // RULE13
        end
        if (ser_wr) begin
            if (sbit_q < {1'b0, nbits})
                empty_d[sbit_q[4:0]] = si_s; // RULE3
            else
                full_d[fpos] = si_s; // RULE3
            sbit_d = (sbit_q + 6'h01 == {nbits, 1'b0}) ? 6'h00
                     : sbit_q + 6'h01; // RULE3
        end
        if (par_rd)
            rd_ptr_d = (rd_ptr_q + 3'h1 == {rd_wpr[1:0], 1'b0}) ? 3'h0
                       : rd_ptr_q + 3'h1; // RULE13
    end

    // Master reset restores defaults and takes the mode straps
    always @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_q             <= 3'h0;
            rd_ptr_q             <= 3'h0;
            sbit_q               <= 6'h00;
            empty_offset         <= `EMPTY_OFS_RST;
            full_offset          <= `FULL_OFS_RST;
            serial_mode          <= 1'b0;
            iw18_q               <= 1'b0;
            ow18_q               <= 1'b0;
            par_q                <= 1'b0;
            fall_through_latched <= 1'b0;
            out_data_bus         <= 18'h00000;
            out_data_valid       <= 1'b0;
            mem_write_pulse      <= 1'b0;
            mem_read_pulse       <= 1'b0;
        end else if (!mrs_n_s) begin
            wr_ptr_q             <= 3'h0; // RULE13
            rd_ptr_q             <= 3'h0; // RULE13
            sbit_q               <= 6'h00;
            empty_offset         <= `EMPTY_OFS_RST;
            full_offset          <= `FULL_OFS_RST;
            serial_mode          <= ~ld_n_s; // RULE10
            iw18_q               <= iw_s;
            ow18_q               <= ow_s;
            par_q                <= par_s;
            fall_through_latched <= ffm_s; // RULE11
            out_data_valid       <= 1'b0;
            mem_write_pulse      <= 1'b0;
            mem_read_pulse       <= 1'b0;
        end else begin
            wr_ptr_q        <= wr_ptr_d;
            rd_ptr_q        <= rd_ptr_d;
            sbit_q          <= sbit_d;
            empty_offset    <= empty_d;
            full_offset     <= full_d;
            out_data_valid  <= par_rd;
            mem_write_pulse <= mem_wr; // RULE14
            mem_read_pulse  <= mem_rd; // RULE14
            if (par_rd)
                out_data_bus <= rd_word; // RULE2
        end
    end

endmodule

//--- tb/fifo_flag_offset_programmer_checker.sv
// Assertion checker for the flag offset register bank
`timescale 1ns/10ps
`include "offset_prog_defines.vh"
module fifo_flag_offset_programmer_checker (
    // Clock and reset
    input wire              sys_clk,
    input wire              sys_rst,
    // Controller pins and straps
    input wire              master_reset_n,
    input wire              offset_load_select_n,
    input wire              wr_en_n,
    input wire              rd_en_n,
    input wire              write_clk_pin,
    input wire              read_clk_pin,
    input wire              in_width_sel,
    input wire              out_width_sel,
    // Watched outputs
    input wire [`BUS_W-1:0] out_data_bus,
    input wire              out_data_valid,
    input wire              mem_write_pulse,
    input wire              mem_read_pulse,
    input wire [`OFS_W-1:0] empty_offset,
    input wire [`OFS_W-1:0] full_offset,
    input wire              serial_mode,
    input wire              fall_through_latched
);
    // ----------------
    // Helpers
    // ----------------
    // Pin history, since the synchroniser delays master reset
    logic [5:0] mr_hist_q;
    wire        mr_quiet = (&mr_hist_q) & master_reset_n;
    always @(posedge sys_clk or posedge sys_rst)
        if (sys_rst) mr_hist_q <= 6'h00;
        else mr_hist_q <= {mr_hist_q[4:0], master_reset_n};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    sequence s_rd_seen;
        ($past(read_clk_pin, 2) || $past(read_clk_pin, 3)) && !rd_en_n && !offset_load_select_n;
    endsequence
    sequence s_wr_seen;
        ($past(write_clk_pin, 2) || $past(write_clk_pin, 3)) && !offset_load_select_n;
    endsequence
    property p_rd_word;
        out_data_valid |-> s_rd_seen ##1 !out_data_valid;
    endproperty
    a_rd_word: assert property (p_rd_word) else $error("stray readback");
    property p_out_hold;
        mr_quiet && $changed(out_data_bus) |-> out_data_valid;
    endproperty
    a_out_hold: assert property (p_out_hold) else $error("readback moved");
    property p_ofs_src;
        mr_quiet && ($changed(empty_offset) || $changed(full_offset)) |-> s_wr_seen;
    endproperty
    a_ofs_src: assert property (p_ofs_src) else $error("offset moved");
    property p_ofs_hold;
        mr_quiet && offset_load_select_n && $past(offset_load_select_n, 4)
            |-> $stable(empty_offset) && $stable(full_offset);
    endproperty
    a_ofs_hold: assert property (p_ofs_hold) else $error("offset hit");
    property p_mem_wr;
        mem_write_pulse |-> offset_load_select_n && !wr_en_n ##1 !mem_write_pulse;
    endproperty
    a_mem_wr: assert property (p_mem_wr) else $error("bad memory write");
    property p_mem_rd;
        mem_read_pulse |-> offset_load_select_n && !rd_en_n ##1 !mem_read_pulse;
    endproperty
    a_mem_rd: assert property (p_mem_rd) else $error("bad memory read");
    property p_width;
        mr_quiet && (in_width_sel || out_width_sel) |-> !empty_offset[16] && !full_offset[16];
    endproperty
    a_width: assert property (p_width) else $error("bit 17 kept");
    property p_mode_hold;
        mr_quiet |-> $stable(serial_mode) && $stable(fall_through_latched);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode moved");
endmodule

bind fifo_flag_offset_programmer fifo_flag_offset_programmer_checker u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .master_reset_n(master_reset_n),
    .offset_load_select_n(offset_load_select_n), .wr_en_n(wr_en_n), .rd_en_n(rd_en_n),
    .write_clk_pin(write_clk_pin), .read_clk_pin(read_clk_pin),
    .in_width_sel(in_width_sel), .out_width_sel(out_width_sel),
    .out_data_bus(out_data_bus), .out_data_valid(out_data_valid),
    .mem_write_pulse(mem_write_pulse), .mem_read_pulse(mem_read_pulse),
    .empty_offset(empty_offset), .full_offset(full_offset),
    .serial_mode(serial_mode), .fall_through_latched(fall_through_latched));

//--- tb/offset_controller_model.sv
// Behavioural controller driving the offset programming pins
`timescale 1ns/10ps
module offset_controller_model (
    // Clock
    input  wire         sys_clk,
    // Controller pins
    output logic        offset_load_select_n,
    output logic        wr_en_n,
    output logic        rd_en_n,
    output logic        serial_shift_en_n,
    output logic        serial_in,
    output logic        write_clk_pin,
    output logic        read_clk_pin,
    output logic [17:0] in_data_bus
);
    // ----------------
    // Pin driver
    // ----------------
    // Idle: no offset or memory access
    initial {offset_load_select_n, wr_en_n, rd_en_n, serial_shift_en_n} = 4'hF;
    initial {serial_in, write_clk_pin, read_clk_pin, in_data_bus} = 21'h000000;
    // One access; only one clock pin per call, so never read and write at once
    task automatic op(logic [3:0] lv, logic s, logic [17:0] d, logic rd);
        {offset_load_select_n, wr_en_n, rd_en_n, serial_shift_en_n} <= lv;
        serial_in <= s;
        in_data_bus <= d;
        repeat (3) @(posedge sys_clk);
        if (rd) read_clk_pin <= 1'h1;
        else write_clk_pin <= 1'h1;
        repeat (3) @(posedge sys_clk);
        // Lines let go with the clock fall; hold time is met by then
        {write_clk_pin, read_clk_pin} <= 2'h0;
        in_data_bus <= ~d;
        serial_in <= ~s;
        repeat (3) @(posedge sys_clk);
    endtask
endmodule

//--- tb/fifo_flag_offset_programmer_test.sv
// Self-checking bench for the flag offset register bank
`timescale 1ns/10ps
`include "offset_prog_defines.vh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module fifo_flag_offset_programmer_test;
    localparam logic [3:0] lv_pw = 4'h3, lv_pr = 4'h5, lv_ss = 4'h6, lv_mw = 4'hB, lv_mr = 4'hD;
    logic             sys_clk = 1'h0;
    logic             sys_rst = 1'h1;
    logic             mrst_n = 1'h0;
    logic [2:0]       strap = 3'h6;
    logic             ft = 1'h0;
    wire              ld_n, wen_n, ren_n, sen_n, si, wclk, rclk, dv, mwp, mrp, smode, ftl;
    wire [`BUS_W-1:0] din, dout;
    wire [`OFS_W-1:0] eo, fo;
    int               num_errors = 0, cmp_count = 0, cyc = 0, nw = 0, nr = 0;
    logic [2:0]       cfg [7] = '{3'h0, 3'h2, 3'h4, 3'h6, 3'h7, 3'h6, 3'h0};
    offset_controller_model m (.sys_clk(sys_clk), .offset_load_select_n(ld_n), .wr_en_n(wen_n),
        .rd_en_n(ren_n), .serial_shift_en_n(sen_n), .serial_in(si), .write_clk_pin(wclk),
        .read_clk_pin(rclk), .in_data_bus(din));
    fifo_flag_offset_programmer dut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .master_reset_n(mrst_n), .offset_load_select_n(ld_n), .wr_en_n(wen_n),
        .rd_en_n(ren_n), .serial_shift_en_n(sen_n), .serial_in(si), .write_clk_pin(wclk),
        .read_clk_pin(rclk), .in_data_bus(din), .in_width_sel(strap[2]),
        .out_width_sel(strap[1]), .parity_sel(strap[0]), .fall_through_mode(ft),
        .out_data_bus(dout), .out_data_valid(dv), .mem_write_pulse(mwp),
        .mem_read_pulse(mrp), .empty_offset(eo), .full_offset(fo), .serial_mode(smode),
        .fall_through_latched(ftl));
    // Clock, memory strobe counts and hang guard
    always #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        cyc++;
        nw += (mwp === 1'h1);
        nr += (mrp === 1'h1);
        if (cyc == 6000) begin
            num_errors++;
            stop_test();
        end
    end
    // Port word of one offset transfer; lines not carrying bits are zero
    function automatic logic [17:0] word(logic [16:0] v, int i, logic w18, logic par);
        if (w18) return par ? {1'h0, v[15:8], 1'h0, v[7:0]} : {2'h0, v[15:0]};
        return i == 0 ? {10'h000, v[7:0]} : i == 1 ? {10'h000, v[15:8]} : {17'h00000, v[16]};
    endfunction
    // Master reset with straps; load select picks the programming method
    task automatic mreset(logic ld, logic [2:0] c);
        mrst_n <= 1'h0;
        m.offset_load_select_n <= ld;
        strap <= c;
        ft <= 1'($urandom);
        repeat (6) @(posedge sys_clk);
        mrst_n <= 1'h1;
        repeat (4) @(posedge sys_clk);
    endtask
    task automatic stop_test();
        $display("errors %0d comparisons %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Every width and parity layout in parallel mode, then serial at two widths
    initial begin
        logic [16:0] v [2];
        logic [16:0] e [2];
        logic [2:0]  c;
        int          n;
        int          nb;
        void'($urandom(32'h95DB5B0E));
        repeat (16) @(posedge sys_clk);
        sys_rst <= 1'h0;
        foreach (cfg[k]) begin
            c = cfg[k];
            if (k > 0) begin
                m.op(lv_pw, 1'h0, 18'($urandom), 1'h0);
                m.op(lv_pr, 1'h0, 18'($urandom), 1'h1);
            end
            mreset(k < 5, c);
            `CHK(smode, 1'(k >= 5))
            `CHK(ftl, ft)
            `CHK(eo, 17'h0007F)
            v[0] = 17'($urandom);
            v[1] = 17'($urandom);
            nb = (c[2] | c[1]) ? 16 : 17;
            foreach (e[r]) e[r] = v[r] & ((17'h00001 << nb) - 17'h00001);
            if (k >= 5) begin
                m.op(lv_pw, 1'h0, 18'($urandom), 1'h0);
                `CHK(eo, 17'h0007F)
                for (int b = 0; b < 2 * nb; b++) begin
                    if (b == 5) m.op(lv_mw, 1'h0, 18'($urandom), 1'h0);
                    m.op(lv_ss, b < nb ? v[0][b] : v[1][b - nb], 18'($urandom), 1'h0);
                end
            end else begin
                n = c[2] ? 1 : (c[1] ? 2 : 3);
                for (int r = 0; r < 2; r++)
                    for (int i = 0; i < n; i++) begin
                        if (r == 1 && i == 0) m.op(lv_mw, 1'h0, 18'($urandom), 1'h0);
                        m.op(lv_pw, 1'h0, word(v[r], i, c[2], c[0])
                            | (18'($urandom) & ~word(17'h1FFFF, i, c[2], c[0])), 1'h0);
                    end
            end
            `CHK(eo, e[0])
            `CHK(fo, e[1])
            n = c[1] ? 1 : (c[2] ? 2 : 3);
            for (int r = 0; r < 2; r++)
                for (int i = 0; i < n; i++) begin
                    if (r == 1 && i == 0) m.op(lv_mr, 1'h0, 18'($urandom), 1'h1);
                    m.op(lv_pr, 1'h0, 18'($urandom), 1'h1);
                    `CHK(dout, word(e[r], i, c[1], c[0]))
                end
        end
        `CHK(nw, 7)
        `CHK(nr, 7)
        stop_test();
    end
endmodule
